// file: rtcal_alarm.sv
// Alarm registers, alarm compare, seconds trim and write protection
`timescale 1ns/100ps
`default_nettype none

module rtcal_alarm (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic SW_RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Running counters
  input wire logic [7:0] YEAR_CNT_I,
  input wire logic [3:0] MONTH_CNT_I,
  input wire logic [4:0] DAY_CNT_I,
  input wire logic [4:0] HOUR_CNT_I,
  input wire logic [5:0] MIN_CNT_I,
  input wire logic [5:0] SEC_CNT_I,
  input wire logic SEC_UPDATE_I,
  input wire logic COUNTERS_UNSTABLE_I,
  // Seconds trim, alarm and write-protection outputs
  output logic SECONDS_PLUS_ONE_O,
  output logic SECONDS_MINUS_ONE_O,
  output logic ALARM_EVENT_O,
  output logic WRITE_UNLOCKED_O,
  output logic IRQ_O
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      rtcal_pkg::OFF_ALM_YRMON: reg_index = rtcal_pkg::IDX_YRMON;
      rtcal_pkg::OFF_ALM_DAY: reg_index = rtcal_pkg::IDX_DAY;
      rtcal_pkg::OFF_ALM_HM: reg_index = rtcal_pkg::IDX_HM;
      rtcal_pkg::OFF_ALM_SEC: reg_index = rtcal_pkg::IDX_SEC;
      rtcal_pkg::OFF_INT_STATUS: reg_index = rtcal_pkg::IDX_STATUS;
      rtcal_pkg::OFF_INT_MASK: reg_index = rtcal_pkg::IDX_MASK;
      rtcal_pkg::OFF_CONTROL: reg_index = rtcal_pkg::IDX_CONTROL;
      default: reg_index = rtcal_pkg::IDX_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] alm_year_reg;
  logic [3:0] alm_month_reg;
  logic [4:0] alm_day_reg;
  logic [4:0] alm_hour_reg;
  logic [5:0] alm_min_reg;
  logic [5:0] alm_sec_reg;
  logic [1:0] match_sel_reg;
  logic status_alarm_reg;
  logic mask_alarm_reg;
  logic match_prev_reg;
  logic [3:0] lock_timer_reg;
  rtcal_pkg::rtcal_wp_state_type wp_state_reg;
  rtcal_pkg::rtcal_wp_state_type wp_state_next;
  logic match_now;
  logic [2:0] idx;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic unlocked;
  logic protected_idx;
  logic wr_allowed;
  logic [1:0] we_code;
  logic alarm_hit;
  logic [31:0] rdata_next;
  logic err_next;

  assign idx = reg_index(PADDR_I);
  // The edge where the master samples pready high
  assign access_done = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_done = access_done && PWRITE_I;
  assign rd_done = access_done && !PWRITE_I;
  assign unlocked = (wp_state_reg == rtcal_pkg::WP_OPEN);
  assign protected_idx = (idx != rtcal_pkg::IDX_STATUS) && (idx != rtcal_pkg::IDX_NONE);
  // Control write-enable code is never blocked; everything else needs unlock
  assign wr_allowed = wr_done && unlocked;
  assign we_code = PWDATA_I[1:0];

  // ----------------------------------------
  // APB answer, one wait state
  // ----------------------------------------
  always_comb begin
    rdata_next = '0;
    err_next = 1'b0;
    case (idx)
      rtcal_pkg::IDX_YRMON: rdata_next[15:0] = {alm_year_reg, 4'h0, alm_month_reg};
      rtcal_pkg::IDX_DAY: rdata_next[4:0] = alm_day_reg;
      rtcal_pkg::IDX_HM: rdata_next[15:0] = {3'h0, alm_hour_reg, 2'h0, alm_min_reg};
      rtcal_pkg::IDX_SEC: rdata_next[5:0] = alm_sec_reg;
      rtcal_pkg::IDX_STATUS: begin
        rdata_next[rtcal_pkg::ST_ALARM_BIT] = status_alarm_reg;
        rdata_next[rtcal_pkg::ST_UNLOCKED_BIT] = unlocked;
        rdata_next[rtcal_pkg::ST_UNSTABLE_BIT] = COUNTERS_UNSTABLE_I;
      end
      rtcal_pkg::IDX_MASK: rdata_next[rtcal_pkg::ST_ALARM_BIT] = mask_alarm_reg;
      rtcal_pkg::IDX_CONTROL: rdata_next[3:2] = match_sel_reg;
      default: begin
        rdata_next = rtcal_pkg::UNMAPPED_RDATA;
        err_next = 1'b1;
      end
    endcase
    // Locked writes are refused and flagged, except writes to the control and status registers, which are never flagged
    if (PWRITE_I && !unlocked && protected_idx && (idx != rtcal_pkg::IDX_CONTROL)) begin
      err_next = 1'b1;
    end
    if (PWRITE_I) begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= '0;
    end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= err_next;
      PRDATA_O <= rdata_next;
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // Alarm setting registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || SW_RESET_I) begin
      {alm_year_reg, alm_month_reg} <= {rtcal_pkg::RST_ALM_YRMON[15:8],
                                        rtcal_pkg::RST_ALM_YRMON[3:0]};
      alm_day_reg <= rtcal_pkg::RST_ALM_DAY[4:0];
      alm_hour_reg <= rtcal_pkg::RST_ALM_HM[12:8];
      alm_min_reg <= rtcal_pkg::RST_ALM_HM[5:0];
      alm_sec_reg <= rtcal_pkg::RST_ALM_SEC[5:0];
    end else if (wr_allowed) begin
      case (idx)
        rtcal_pkg::IDX_YRMON: begin
          alm_year_reg <= PWDATA_I[rtcal_pkg::YEAR_LSB +: 8];
          alm_month_reg <= PWDATA_I[3:0];
        end
        rtcal_pkg::IDX_DAY: alm_day_reg <= PWDATA_I[4:0];
        rtcal_pkg::IDX_HM: begin
          alm_hour_reg <= PWDATA_I[rtcal_pkg::HOUR_LSB +: 5];
          alm_min_reg <= PWDATA_I[5:0];
        end
        rtcal_pkg::IDX_SEC: alm_sec_reg <= PWDATA_I[5:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Seconds trim pulses
  // ----------------------------------------
  // Each pulse lasts one cycle; software is expected to have checked the
  // counters-unstable flag first, so no second boundary is raced here
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      SECONDS_PLUS_ONE_O <= 1'b0;
      SECONDS_MINUS_ONE_O <= 1'b0;
    end else begin
      SECONDS_PLUS_ONE_O <= wr_allowed && (idx == rtcal_pkg::IDX_SEC) &&
                            PWDATA_I[rtcal_pkg::SEC_INC_BIT];
      SECONDS_MINUS_ONE_O <= wr_allowed && (idx == rtcal_pkg::IDX_SEC) &&
                             PWDATA_I[rtcal_pkg::SEC_DEC_BIT];
    end
  end

  // ----------------------------------------
  // Match select
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || SW_RESET_I) begin
      match_sel_reg <= rtcal_rst_match();
    end else if (wr_allowed && (idx == rtcal_pkg::IDX_CONTROL)) begin
      match_sel_reg <= PWDATA_I[rtcal_pkg::CTRL_MATCH_LSB +: 2];
    end
  end

  function automatic logic [1:0] rtcal_rst_match();
    rtcal_rst_match = rtcal_pkg::RST_MATCH_SEL;
  endfunction

  // ----------------------------------------
  // Write protection
  // ----------------------------------------
  always_comb begin
    wp_state_next = wp_state_reg;
    if (wr_done && (idx == rtcal_pkg::IDX_CONTROL)) begin
      case (wp_state_reg)
        rtcal_pkg::WP_LOCKED:
          wp_state_next = (we_code == rtcal_pkg::WE_STEP0) ? rtcal_pkg::WP_GOT0
                                                           : rtcal_pkg::WP_LOCKED;
        rtcal_pkg::WP_GOT0: begin
          if (we_code == rtcal_pkg::WE_STEP1) begin
            wp_state_next = rtcal_pkg::WP_GOT1;
          end else if (we_code == rtcal_pkg::WE_STEP0) begin
            wp_state_next = rtcal_pkg::WP_GOT0;
          end else begin
            wp_state_next = rtcal_pkg::WP_LOCKED;
          end
        end
        rtcal_pkg::WP_GOT1: begin
          if (we_code == rtcal_pkg::WE_STEP2) begin
            wp_state_next = rtcal_pkg::WP_GOT2;
          end else if (we_code == rtcal_pkg::WE_STEP0) begin
            wp_state_next = rtcal_pkg::WP_GOT0;
          end else begin
            wp_state_next = rtcal_pkg::WP_LOCKED;
          end
        end
        rtcal_pkg::WP_GOT2: begin
          if (we_code == rtcal_pkg::WE_LOCK) begin
            wp_state_next = rtcal_pkg::WP_OPEN;
          end else if (we_code == rtcal_pkg::WE_STEP0) begin
            wp_state_next = rtcal_pkg::WP_GOT0;
          end else begin
            wp_state_next = rtcal_pkg::WP_LOCKED;
          end
        end
        rtcal_pkg::WP_OPEN:
          wp_state_next = (we_code == rtcal_pkg::WE_LOCK) ? rtcal_pkg::WP_LOCKED
                                                          : rtcal_pkg::WP_OPEN;
        default: wp_state_next = rtcal_pkg::WP_LOCKED;
      endcase
    end
    // Automatic relock once the window of seconds runs out
    if (unlocked && SEC_UPDATE_I && (lock_timer_reg == 4'd1) &&
        (wp_state_next == rtcal_pkg::WP_OPEN)) begin
      wp_state_next = rtcal_pkg::WP_LOCKED;
    end
  end

  // Power-up opens a longer window so boot code can configure without unlocking
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      wp_state_reg <= rtcal_pkg::WP_OPEN;
      lock_timer_reg <= rtcal_pkg::POR_UNLOCK_SECONDS;
    end else begin
      wp_state_reg <= wp_state_next;
      if (!unlocked && (wp_state_next == rtcal_pkg::WP_OPEN)) begin
        lock_timer_reg <= rtcal_pkg::UNLOCK_SECONDS;
      end else if (unlocked && SEC_UPDATE_I && (lock_timer_reg != 4'd0)) begin
        lock_timer_reg <= lock_timer_reg - 4'd1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      WRITE_UNLOCKED_O <= 1'b1;
    end else begin
      WRITE_UNLOCKED_O <= (wp_state_next == rtcal_pkg::WP_OPEN);
    end
  end

  // ----------------------------------------
  // Alarm compare
  // ----------------------------------------
  rtcal_match rtcal_match_i (
    .match_sel_i(match_sel_reg),
    .alm_year_i(alm_year_reg),
    .alm_month_i(alm_month_reg),
    .alm_day_i(alm_day_reg),
    .alm_hour_i(alm_hour_reg),
    .alm_min_i(alm_min_reg),
    .alm_sec_i(alm_sec_reg),
    .cnt_year_i(YEAR_CNT_I),
    .cnt_month_i(MONTH_CNT_I),
    .cnt_day_i(DAY_CNT_I),
    .cnt_hour_i(HOUR_CNT_I),
    .cnt_min_i(MIN_CNT_I),
    .cnt_sec_i(SEC_CNT_I),
    .match_o(match_now)
  );

  // Only a fresh match counts, so a held time does not retrigger
  assign alarm_hit = SEC_UPDATE_I && match_now && !match_prev_reg;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || SW_RESET_I) begin
      match_prev_reg <= 1'b0;
      ALARM_EVENT_O <= 1'b0;
    end else begin
      if (SEC_UPDATE_I) begin
        match_prev_reg <= match_now;
      end
      ALARM_EVENT_O <= alarm_hit;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // A hit in the same cycle as the clearing read keeps the bit set
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || SW_RESET_I) begin
      status_alarm_reg <= 1'b0;
    end else if (alarm_hit) begin
      status_alarm_reg <= 1'b1;
    end else if (rd_done && (idx == rtcal_pkg::IDX_STATUS)) begin
      status_alarm_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || SW_RESET_I) begin
      mask_alarm_reg <= 1'b0;
    end else if (wr_allowed && (idx == rtcal_pkg::IDX_MASK)) begin
      mask_alarm_reg <= PWDATA_I[rtcal_pkg::ST_ALARM_BIT];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || SW_RESET_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= status_alarm_reg && mask_alarm_reg;
    end
  end

endmodule

`default_nettype wire

// file: rtcal_pkg.sv
// Shared constants for the alarm compare and seconds trim block
package rtcal_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_ALM_YRMON = 8'h00;
  localparam logic [7:0] OFF_ALM_DAY = 8'h04;
  localparam logic [7:0] OFF_ALM_HM = 8'h08;
  localparam logic [7:0] OFF_ALM_SEC = 8'h0c;
  localparam logic [7:0] OFF_INT_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_CONTROL = 8'h18;

  // Decoded register index
  localparam logic [2:0] IDX_YRMON = 3'h0;
  localparam logic [2:0] IDX_DAY = 3'h1;
  localparam logic [2:0] IDX_HM = 3'h2;
  localparam logic [2:0] IDX_SEC = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;
  localparam logic [2:0] IDX_MASK = 3'h5;
  localparam logic [2:0] IDX_CONTROL = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int YEAR_LSB = 8;
  localparam int HOUR_LSB = 8;
  localparam int SEC_INC_BIT = 9;
  localparam int SEC_DEC_BIT = 8;
  localparam int CTRL_MATCH_LSB = 2;
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_UNLOCKED_BIT = 1;
  localparam int ST_UNSTABLE_BIT = 2;

  // ----------------------------------------
  // Reset values and unmapped read data
  // ----------------------------------------
  localparam logic [15:0] RST_ALM_YRMON = 16'h0000;
  localparam logic [15:0] RST_ALM_DAY = 16'h0000;
  localparam logic [15:0] RST_ALM_HM = 16'h0000;
  localparam logic [15:0] RST_ALM_SEC = 16'h0000;
  localparam logic [1:0] RST_MATCH_SEL = 2'h0;
  localparam logic [31:0] UNMAPPED_RDATA = 32'hffff_ffff;

  // ----------------------------------------
  // Match select, month wildcard and unlock sequence codes
  // ----------------------------------------
  localparam logic [1:0] MATCH_HMS = 2'h0;
  localparam logic [1:0] MATCH_DAY = 2'h1;
  localparam logic [1:0] MATCH_MONTH = 2'h2;
  localparam logic [1:0] MATCH_YEAR = 2'h3;
  localparam logic [1:0] WE_STEP0 = 2'h0;
  localparam logic [1:0] WE_STEP1 = 2'h1;
  localparam logic [1:0] WE_STEP2 = 2'h3;
  localparam logic [1:0] WE_LOCK = 2'h2;
  localparam logic [3:0] MONTH_NO_MATCH = 4'h0;

  // ----------------------------------------
  // Timing, in seconds-counter updates
  // ----------------------------------------
  localparam logic [3:0] UNLOCK_SECONDS = 4'd2;
  localparam logic [3:0] POR_UNLOCK_SECONDS = 4'd15;

  typedef enum logic [2:0] {
    WP_LOCKED = 3'b000,
    WP_GOT0 = 3'b001,
    WP_GOT1 = 3'b010,
    WP_GOT2 = 3'b011,
    WP_OPEN = 3'b100
  } rtcal_wp_state_type;

endpackage

// file: rtcal_match.sv
// Alarm-to-counter comparator with selectable match depth
`timescale 1ns/100ps
`default_nettype none

module rtcal_match (
  // Match depth
  input wire logic [1:0] match_sel_i,
  // Alarm settings
  input wire logic [7:0] alm_year_i,
  input wire logic [3:0] alm_month_i,
  input wire logic [4:0] alm_day_i,
  input wire logic [4:0] alm_hour_i,
  input wire logic [5:0] alm_min_i,
  input wire logic [5:0] alm_sec_i,
  // Running counters
  input wire logic [7:0] cnt_year_i,
  input wire logic [3:0] cnt_month_i,
  input wire logic [4:0] cnt_day_i,
  input wire logic [4:0] cnt_hour_i,
  input wire logic [5:0] cnt_min_i,
  input wire logic [5:0] cnt_sec_i,
  // Result
  output logic match_o
);

  logic hms_eq;
  logic day_eq;
  logic month_eq;
  logic year_eq;

  assign hms_eq = (alm_sec_i == cnt_sec_i) && (alm_min_i == cnt_min_i) &&
                  (alm_hour_i == cnt_hour_i);
  assign day_eq = (alm_day_i == cnt_day_i);
  // A zero month setting skips the month compare
  assign month_eq = (alm_month_i == rtcal_pkg::MONTH_NO_MATCH) ||
                    (alm_month_i == cnt_month_i);
  // Signed offsets compare bit for bit
  assign year_eq = (alm_year_i == cnt_year_i);

  always_comb begin
    case (match_sel_i)
      rtcal_pkg::MATCH_HMS: match_o = hms_eq;
      rtcal_pkg::MATCH_DAY: match_o = hms_eq && day_eq;
      rtcal_pkg::MATCH_MONTH: match_o = hms_eq && day_eq && month_eq;
      rtcal_pkg::MATCH_YEAR: match_o = hms_eq && day_eq && month_eq && year_eq;
      default: match_o = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// file: rtcal_alarm_checker.sv
// Assertion checker for the alarm compare and seconds trim block
`timescale 1ns/100ps
`default_nettype none

module rtcal_alarm_checker (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic SW_RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic SEC_UPDATE_I,
  input wire logic SECONDS_PLUS_ONE_O,
  input wire logic SECONDS_MINUS_ONE_O,
  input wire logic ALARM_EVENT_O,
  input wire logic WRITE_UNLOCKED_O,
  input wire logic IRQ_O
);
  logic wr_ok;
  logic rd_end;
  logic sec_adr;
  assign wr_ok = PREADY_O && PSEL_I && PWRITE_I && !PSLVERR_O;
  assign rd_end = PREADY_O && PSEL_I && !PWRITE_I;
  assign sec_adr = PADDR_I == 8'h0c;

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  chk_ready_late: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
    else $error("no answer after access cycle");
  chk_ready_once: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  chk_read_free: assert property (rd_end && PADDR_I[1:0] == 2'h0 && PADDR_I <= 8'h18
    |-> !PSLVERR_O)
    else $error("read of mapped register refused");
  chk_sec_zero: assert property (rd_end && sec_adr |-> PRDATA_O[31:6] == 26'h0)
    else $error("trim or reserved bits read nonzero");
  chk_locked_err: assert property (PREADY_O && PWRITE_I && PADDR_I < 8'h10
    && !WRITE_UNLOCKED_O && $stable(WRITE_UNLOCKED_O) |-> PSLVERR_O)
    else $error("locked write not refused");

  // ----------------------------------------
  // Trim and alarm
  // ----------------------------------------
  chk_plus_trim: assert property (wr_ok && sec_adr && PWDATA_I[9] |=> SECONDS_PLUS_ONE_O)
    else $error("missing plus pulse");
  chk_minus_trim: assert property (wr_ok && sec_adr && PWDATA_I[8] |=> SECONDS_MINUS_ONE_O)
    else $error("missing minus pulse");
  chk_trim_self: assert property (SECONDS_PLUS_ONE_O || SECONDS_MINUS_ONE_O
    |=> !SECONDS_PLUS_ONE_O && !SECONDS_MINUS_ONE_O)
    else $error("trim pulse not cleared");
  chk_event_cause: assert property (!SEC_UPDATE_I ##1 !SEC_UPDATE_I |=> !ALARM_EVENT_O)
    else $error("alarm event without seconds update");
  chk_swr_irq: assert property (SW_RESET_I |=> ##1 !IRQ_O)
    else $error("interrupt survives software reset");
endmodule

bind rtcal_alarm rtcal_alarm_checker rtcal_alarm_checker_i (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SW_RESET_I(SW_RESET_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .SEC_UPDATE_I(SEC_UPDATE_I), .SECONDS_PLUS_ONE_O(SECONDS_PLUS_ONE_O),
  .SECONDS_MINUS_ONE_O(SECONDS_MINUS_ONE_O), .ALARM_EVENT_O(ALARM_EVENT_O),
  .WRITE_UNLOCKED_O(WRITE_UNLOCKED_O), .IRQ_O(IRQ_O));

`default_nettype wire

// file: rtcal_alarm_bench.sv
// Self-checking bench for the alarm compare and seconds trim block
`timescale 1ns/100ps
`default_nettype none

module rtcal_alarm_bench;
  logic CLK_SYS_I, RST_I, SW_RESET_I, PSEL_I, PENABLE_I, PWRITE_I;
  logic [7:0] PADDR_I, YEAR_CNT_I;
  logic [31:0] PWDATA_I, PRDATA_O, rdat;
  logic PREADY_O, PSLVERR_O, rerr, ev;
  logic [3:0] MONTH_CNT_I;
  logic [4:0] DAY_CNT_I, HOUR_CNT_I;
  logic [5:0] MIN_CNT_I, SEC_CNT_I;
  logic SEC_UPDATE_I, COUNTERS_UNSTABLE_I, SECONDS_PLUS_ONE_O, SECONDS_MINUS_ONE_O;
  logic ALARM_EVENT_O, WRITE_UNLOCKED_O, IRQ_O;
  logic [1:0] we [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int errors, compares, cyc;

  rtcal_alarm rtcal_alarm_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SW_RESET_I(SW_RESET_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .YEAR_CNT_I(YEAR_CNT_I), .MONTH_CNT_I(MONTH_CNT_I), .DAY_CNT_I(DAY_CNT_I),
    .HOUR_CNT_I(HOUR_CNT_I), .MIN_CNT_I(MIN_CNT_I), .SEC_CNT_I(SEC_CNT_I),
    .SEC_UPDATE_I(SEC_UPDATE_I), .COUNTERS_UNSTABLE_I(COUNTERS_UNSTABLE_I),
    .SECONDS_PLUS_ONE_O(SECONDS_PLUS_ONE_O), .SECONDS_MINUS_ONE_O(SECONDS_MINUS_ONE_O),
    .ALARM_EVENT_O(ALARM_EVENT_O), .WRITE_UNLOCKED_O(WRITE_UNLOCKED_O), .IRQ_O(IRQ_O));

  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  initial begin
    CLK_SYS_I = 1'b0;
    forever #25 CLK_SYS_I = ~CLK_SYS_I;
  end

  always @(posedge CLK_SYS_I) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge CLK_SYS_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_SYS_I);
    PENABLE_I <= 1'b1;
    @(posedge CLK_SYS_I);
    // Only the cycle ceiling ends a wait that never gets an answer
    while (PREADY_O !== 1'b1) @(posedge CLK_SYS_I);
    rdat = PRDATA_O;
    rerr = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    xfer(a, 1'b1, d);
    check({31'h0, rerr}, {31'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    check(rdat, x);
  endtask

  // Lock first so the start state is known, open, then land the match select
  task automatic unlock(input logic [1:0] m);
    xfer(8'h18, 1'b1, {28'h0, m, 2'h2});
    for (int j = 0; j < 4; j++) xfer(8'h18, 1'b1, {28'h0, m, we[j]});
    xfer(8'h18, 1'b1, {28'h0, m, 2'h0});
    @(negedge CLK_SYS_I);
  endtask

  // Counters that match the programmed alarm except the field picked by bad
  task automatic setc(input int bad);
    YEAR_CNT_I <= 8'h97 ^ {7'h0, bad == 3};
    MONTH_CNT_I <= 4'h5 ^ {3'h0, bad == 2};
    DAY_CNT_I <= 5'h11 ^ {4'h0, bad == 1};
    HOUR_CNT_I <= 5'h0d;
    MIN_CNT_I <= 6'h2a;
    SEC_CNT_I <= 6'h07 ^ {5'h0, bad == 0};
  endtask

  // Counters change with the update pulse; the event stands in the cycle after it
  task automatic tick(input int bad);
    @(posedge CLK_SYS_I);
    setc(bad);
    SEC_UPDATE_I <= 1'b1;
    @(posedge CLK_SYS_I);
    SEC_UPDATE_I <= 1'b0;
    @(negedge CLK_SYS_I);
    ev = ALARM_EVENT_O;
    @(negedge CLK_SYS_I);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {RST_I, SW_RESET_I, PSEL_I, PENABLE_I, PWRITE_I, SEC_UPDATE_I} = 6'h20;
    {PADDR_I, PWDATA_I} = 40'h0;
    COUNTERS_UNSTABLE_I = 1'b1;
    errors = 0;
    compares = 0;
    cyc = 0;
    setc(4);
    repeat (3) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4), 32'h0);
      wr(8'(i * 4), (i == 3) ? 32'hffff_fcff : 32'hffff_ffff, 1'b0);
      rd(8'(i * 4), (i == 0) ? 32'hff0f : (i == 1) ? 32'h1f : (i == 2) ? 32'h1f3f : 32'h3f);
    end
    $display("Test fields done");
    rd(8'h10, 32'h6);
    COUNTERS_UNSTABLE_I <= 1'b0;
    rd(8'h10, 32'h2);
    for (int k = 1; k < 4; k++) begin
      wr(8'h0c, 32'h3f | (k << 8), 1'b0);
      @(negedge CLK_SYS_I);
      check({30'h0, SECONDS_PLUS_ONE_O, SECONDS_MINUS_ONE_O}, 32'(k));
      @(negedge CLK_SYS_I);
      check({30'h0, SECONDS_PLUS_ONE_O, SECONDS_MINUS_ONE_O}, 32'h0);
    end
    rd(8'h0c, 32'h3f);
    $display("Test trim done");
    @(posedge CLK_SYS_I);
    SW_RESET_I <= 1'b1;
    @(posedge CLK_SYS_I);
    SW_RESET_I <= 1'b0;
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0);
    wr(8'h00, 32'h9705, 1'b0);
    wr(8'h04, 32'h11, 1'b0);
    wr(8'h08, 32'h0d2a, 1'b0);
    wr(8'h0c, 32'h07, 1'b0);
    $display("Test soft reset done");
    for (int m = 0; m < 4; m++) begin
      unlock(2'(m));
      check({31'h0, WRITE_UNLOCKED_O}, 32'h1);
      wr(8'h14, {31'h0, m != 0}, 1'b0);
      tick(m);
      check({31'h0, ev}, 32'h0);
      tick((m == 3) ? 4 : m + 1);
      check({31'h0, ev}, 32'h1);
      check({31'h0, IRQ_O}, {31'h0, m != 0});
      tick((m == 3) ? 4 : m + 1);
      check({31'h0, ev}, 32'h0);
      check({31'h0, WRITE_UNLOCKED_O}, 32'h0);
      xfer(8'h10, 1'b0, 32'h0);
      check({31'h0, rdat[0]}, 32'h1);
      repeat (2) @(negedge CLK_SYS_I);
      check({31'h0, IRQ_O}, 32'h0);
    end
    $display("Test match modes done");
    wr(8'h04, 32'h1e, 1'b1);
    rd(8'h04, 32'h11);
    rd(8'h1c, 32'hffff_ffff);
    check({31'h0, rerr}, 32'h1);
    unlock(2'h2);
    wr(8'h00, 32'h9700, 1'b0);
    tick(0);
    tick(2);
    check({31'h0, ev}, 32'h1);
    check({31'h0, IRQ_O}, 32'h1);
    @(posedge CLK_SYS_I);
    SW_RESET_I <= 1'b1;
    @(posedge CLK_SYS_I);
    SW_RESET_I <= 1'b0;
    @(negedge CLK_SYS_I);
    check({31'h0, IRQ_O}, 32'h0);
    rd(8'h00, 32'h0);
    $display("Test lock and month wildcard done");
    close_out();
  end
endmodule

`default_nettype wire
